/* timer_waveform_channel_consts.svh */
// Offsets, field positions, codes and reset values of the waveform channel.
// Assumes byte addresses on an 8-bit register address.
`ifndef TIMER_WAVEFORM_CHANNEL_CONSTS_SVH
`define TIMER_WAVEFORM_CHANNEL_CONSTS_SVH

// ==========================================
// Register offsets
`define TWC_CTRL_OFS 8'h00
`define TWC_MODE_OFS 8'h04
`define TWC_COUNT_OFS 8'h10
`define TWC_CMPA_OFS 8'h14
`define TWC_CMPB_OFS 8'h18
`define TWC_CMPC_OFS 8'h1c
`define TWC_STATUS_OFS 8'h20

// ==========================================
// Control command bits
`define TWC_CTRL_CLKEN 0
`define TWC_CTRL_CLKDIS 1
`define TWC_CTRL_SOFT_TRIGGER_CMD 2

// ==========================================
// Status bits
`define TWC_SR_MATCH_A 2
`define TWC_SR_MATCH_B 3
`define TWC_SR_MATCH_C 4
`define TWC_SR_EVENT 7
`define TWC_SR_CLK_ON 16
`define TWC_SR_MIRROR_A 17
`define TWC_SR_MIRROR_B 18

// ==========================================
// Field codes
`define TWC_ACT_NONE 2'h0
`define TWC_ACT_SET 2'h1
`define TWC_ACT_CLEAR 2'h2
`define TWC_ACT_TOGGLE 2'h3
`define TWC_EVT_FROM_IOB 2'h0
`define TWC_SHAPE_UP 2'h0
`define TWC_SHAPE_UP_TRIG 2'h2

// ==========================================
// Reset values
`define TWC_MODE_RST 32'h0000_0000
`define TWC_CMP_RST 16'h0000

`endif

/* timer_waveform_channel_pkg.sv */
// Types shared by the waveform channel: the mode register layout.
// Assumes the constants header is included by the user of the package.
`default_nettype none

package timer_waveform_channel_pkg;

	// Mode register, bit 31 first
	typedef struct packed {
		logic [1:0] outbOnSoftTrigger;
		logic [1:0] outbOnEvent;
		logic [1:0] outbOnMatchC;
		logic [1:0] outbOnMatchB;
		logic [1:0] outaOnSoftTrigger;
		logic [1:0] outaOnEvent;
		logic [1:0] outaOnMatchC;
		logic [1:0] outaOnMatchA;
		logic waveMode;
		logic [1:0] waveformShapeSelect;
		logic eventRestartEnable;
		logic [1:0] eventSourceSelect;
		logic [1:0] eventEdgeSelect;
		logic disableOnTopMatch;
		logic stopOnTopMatch;
		logic [1:0] gateSelect;
		logic countEdgeInvert;
		logic [2:0] clockSourceSelect;
	} mode_t;

	typedef logic [3:0][1:0] action_set_t;

endpackage

`default_nettype wire

/* timer_waveform_channel.sv */
// One 16-bit timer channel in waveform mode with its register port.
// Assumes clock and event inputs are synchronous to core_clk and
// change no faster than every second cycle.
//
// Overview of operation
// - Three-bit source picks prescaled clock or external clock; optional falling-edge count.
// - Two-bit gate field ANDs selected clock with external clock 0, 1 or 2.
// - Stop-on-top stops the counter clock when the counter reaches compare_c.
// - Disable-on-top disables the counter clock when the counter reaches compare_c.
// - Event edge field: none, rising, falling or both edges qualify an event.
// - Event source field picks chan_io_b as input or an external clock.
// - With chan_io_b as event source it is input only, no waveform.
// - Without restart enable, events only drive the output lines and the event status flag, not the counter.
// - With restart enable, each event zeroes the counter and starts its clock.
// - Shape field selects up or up/down counting; up can restart on compare_c, up/down can turn at compare_c.
// - Mode bit 15 set selects waveform operation; clear leaves waveform fields inert except the shape field, which still selects up/down counting.
// - Four action fields set, clear or toggle chan_io_a per source.
// - Four action fields set, clear or toggle chan_io_b per source.
// - Count value register is read-only and returns the live counter.
// - Compare_a and compare_b take writes only in waveform operation.
// - Reading compare_a returns its current value directly.
// - Reading compare_b returns its current value directly.
// - Reading compare_c returns its current value directly.
// - Software trigger zeroes the counter, starts its clock, fires trigger actions.
// - Compare_c match sets a sticky flag cleared by the next status read.
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "timer_waveform_channel_consts.svh"
`default_nettype none

module timer_waveform_channel
	import timer_waveform_channel_pkg::*;
#(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// Counter clock sources
	input wire logic [4:0] prescaledClk,
	input wire logic [2:0] extClk,
	// Channel lines
	input wire logic chanIoBIn,
	output logic chanIoAOut,
	output logic chanIoAOe,
	output logic chanIoBOut,
	output logic chanIoBOe
);

	// ==========================================
	// Reset release
	logic rstMeta_q;
	logic rstSync_q;
	logic rstN;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end
	assign rstN = rstSync_q;

	// ==========================================
	// Register decode
	mode_t mode_q;
	logic [CNT_W-1:0] count_q, cmpA_q, cmpB_q, cmpC_q;
	logic ctrlWr, swTrig, clkOn, clkOff, statusRd;

	assign ctrlWr = regWr && regAddr == `TWC_CTRL_OFS;
	assign swTrig = ctrlWr && regWdata[`TWC_CTRL_SOFT_TRIGGER_CMD];
	assign clkOn = ctrlWr && regWdata[`TWC_CTRL_CLKEN];
	assign clkOff = ctrlWr && regWdata[`TWC_CTRL_CLKDIS];
	assign statusRd = regRd && regAddr == `TWC_STATUS_OFS;

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			mode_q <= mode_t'(`TWC_MODE_RST);
			cmpA_q <= `TWC_CMP_RST;
			cmpB_q <= `TWC_CMP_RST;
			cmpC_q <= `TWC_CMP_RST;
		end else if (regWr) begin
			case (regAddr)
				`TWC_MODE_OFS: mode_q <= mode_t'(regWdata);
				// Capture operation owns these, so software may not disturb them
				`TWC_CMPA_OFS: if (mode_q.waveMode) cmpA_q <= regWdata[CNT_W-1:0];
				`TWC_CMPB_OFS: if (mode_q.waveMode) cmpB_q <= regWdata[CNT_W-1:0];
				`TWC_CMPC_OFS: cmpC_q <= regWdata[CNT_W-1:0];
				default: ;
			endcase
		end
	end

	// ==========================================
	// Counter clock selection and gating
	logic selClk, gateOk, cntClk, prevClk_q;
	logic clkEn_q, clkRun_q, tick;

	always_comb begin
		case (mode_q.clockSourceSelect)
			3'h0: selClk = prescaledClk[0];
			3'h1: selClk = prescaledClk[1];
			3'h2: selClk = prescaledClk[2];
			3'h3: selClk = prescaledClk[3];
			3'h4: selClk = prescaledClk[4];
			3'h5: selClk = extClk[0];
			3'h6: selClk = extClk[1];
			default: selClk = extClk[2];
		endcase
		case (mode_q.gateSelect)
			2'h0: gateOk = 1'b1;
			2'h1: gateOk = extClk[0];
			2'h2: gateOk = extClk[1];
			default: gateOk = extClk[2];
		endcase
	end

	// Inverting first turns a falling source edge into a rising count edge
	assign cntClk = (selClk ^ mode_q.countEdgeInvert) & gateOk;
	assign tick = cntClk && !prevClk_q && clkEn_q && clkRun_q;

	// ==========================================
	// External event
	logic evtSig, prevEvt_q, evtRise, evtFall, evtQual, bIsInput;

	always_comb begin
		case (mode_q.eventSourceSelect)
			2'h0: evtSig = chanIoBIn;
			2'h1: evtSig = extClk[0];
			2'h2: evtSig = extClk[1];
			default: evtSig = extClk[2];
		endcase
	end

	assign bIsInput = mode_q.eventSourceSelect == `TWC_EVT_FROM_IOB;
	assign evtRise = evtSig && !prevEvt_q;
	assign evtFall = !evtSig && prevEvt_q;
	assign evtQual = mode_q.waveMode && ((mode_q.eventEdgeSelect[0] && evtRise) ||
		(mode_q.eventEdgeSelect[1] && evtFall));

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			prevClk_q <= 1'b0;
			prevEvt_q <= 1'b0;
		end else begin
			prevClk_q <= cntClk;
			prevEvt_q <= evtSig;
		end
	end

	// ==========================================
	// Compares and triggers
	logic cntNew_q, matchA, matchB, matchC, autoTrig, trig;

	// Compare only on a fresh count so a parked counter matches once
	assign matchA = mode_q.waveMode && cntNew_q && count_q == cmpA_q;
	assign matchB = mode_q.waveMode && cntNew_q && count_q == cmpB_q;
	assign matchC = mode_q.waveMode && cntNew_q && count_q == cmpC_q;
	assign autoTrig = matchC && mode_q.waveformShapeSelect == `TWC_SHAPE_UP_TRIG;
	// An event restarts the counter only when restart is enabled
	assign trig = swTrig || (evtQual && mode_q.eventRestartEnable) || autoTrig;

	// ==========================================
	// Counter
	logic dirDown_q, nextDir;
	logic [CNT_W-1:0] nextCount, topVal;

	always_comb begin
		topVal = mode_q.waveformShapeSelect[1] ? cmpC_q : {CNT_W{1'b1}};
		nextDir = dirDown_q;
		if (!mode_q.waveformShapeSelect[0]) begin
			nextCount = count_q + 1'b1;
			nextDir = 1'b0;
		end else if (dirDown_q && count_q == '0) begin
			nextCount = count_q + 1'b1;
			nextDir = 1'b0;
		end else if (dirDown_q) begin
			nextCount = count_q - 1'b1;
		end else if (count_q >= topVal) begin
			nextCount = count_q - 1'b1;
			nextDir = 1'b1;
		end else begin
			nextCount = count_q + 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			count_q <= '0;
			dirDown_q <= 1'b0;
			cntNew_q <= 1'b0;
		end else if (trig) begin
			count_q <= '0;
			dirDown_q <= 1'b0;
			cntNew_q <= 1'b0;
		end else begin
			cntNew_q <= tick;
			if (tick) begin
				count_q <= nextCount;
				dirDown_q <= nextDir;
			end
		end
	end

	// ==========================================
	// Counter clock enable and run state
	// Disable needs a new enable command and a trigger; stop only needs a trigger
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			clkEn_q <= 1'b0;
		end else if (clkOff || (matchC && mode_q.disableOnTopMatch)) begin
			clkEn_q <= 1'b0;
		end else if (clkOn) begin
			clkEn_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			clkRun_q <= 1'b0;
		end else if (matchC && (mode_q.stopOnTopMatch || mode_q.disableOnTopMatch)) begin
			clkRun_q <= 1'b0;
		end else if (trig) begin
			clkRun_q <= 1'b1;
		end
	end

	// ==========================================
	// Sticky status flags, set wins over the read clear
	logic [3:0] flag_q, flagSet;

	assign flagSet = {evtQual, matchC, matchB, matchA};
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			flag_q <= '0;
		end else begin
			flag_q <= (statusRd ? 4'h0 : flag_q) | flagSet;
		end
	end

	// ==========================================
	// Output lines
	action_set_t actSel [2];
	logic [3:0] fire [2];
	logic [1:0] ioLevel;

	assign actSel[0] = {mode_q.outaOnSoftTrigger, mode_q.outaOnEvent,
		mode_q.outaOnMatchC, mode_q.outaOnMatchA};
	assign actSel[1] = {mode_q.outbOnSoftTrigger, mode_q.outbOnEvent,
		mode_q.outbOnMatchC, mode_q.outbOnMatchB};
	assign fire[0] = mode_q.waveMode ? {swTrig, evtQual, matchC, matchA} : 4'h0;
	// An input line produces no waveform at all
	assign fire[1] = (mode_q.waveMode && !bIsInput) ?
		{swTrig, evtQual, matchC, matchB} : 4'h0;

	for (genvar i = 0; i < 2; i++) begin : g_line
		logic [1:0] act;
		logic out_q;

		// Later sources win: software trigger over event over compare_c over own compare
		always_comb begin
			act = `TWC_ACT_NONE;
			for (int k = 0; k < 4; k++) begin
				if (fire[i][k]) begin
					act = actSel[i][k];
				end
			end
		end

		always_ff @(posedge core_clk or negedge rstN) begin
			if (!rstN) begin
				out_q <= 1'b0;
			end else begin
				case (act)
					`TWC_ACT_SET: out_q <= 1'b1;
					`TWC_ACT_CLEAR: out_q <= 1'b0;
					`TWC_ACT_TOGGLE: out_q <= !out_q;
					default: ;
				endcase
			end
		end
		assign ioLevel[i] = out_q;
	end

	assign chanIoAOut = ioLevel[0];
	assign chanIoBOut = ioLevel[1];
	assign chanIoAOe = mode_q.waveMode;
	assign chanIoBOe = mode_q.waveMode && !bIsInput;

	// ==========================================
	// Read data, valid only in the cycle after the strobe
	logic [31:0] statusWord;

	always_comb begin
		statusWord = '0;
		statusWord[`TWC_SR_MATCH_A] = flag_q[0];
		statusWord[`TWC_SR_MATCH_B] = flag_q[1];
		statusWord[`TWC_SR_MATCH_C] = flag_q[2];
		statusWord[`TWC_SR_EVENT] = flag_q[3];
		statusWord[`TWC_SR_CLK_ON] = clkEn_q;
		statusWord[`TWC_SR_MIRROR_A] = ioLevel[0];
		statusWord[`TWC_SR_MIRROR_B] = ioLevel[1];
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			regRdata <= '0;
		end else if (regRd) begin
			case (regAddr)
				`TWC_MODE_OFS: regRdata <= mode_q;
				`TWC_COUNT_OFS: regRdata <= 32'(count_q);
				`TWC_CMPA_OFS: regRdata <= 32'(cmpA_q);
				`TWC_CMPB_OFS: regRdata <= 32'(cmpB_q);
				`TWC_CMPC_OFS: regRdata <= 32'(cmpC_q);
				`TWC_STATUS_OFS: regRdata <= statusWord;
				default: regRdata <= '0;
			endcase
		end else begin
			regRdata <= '0;
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstN);

	sequence swWriteSeq;
		regWr && regAddr == `TWC_CTRL_OFS && regWdata[`TWC_CTRL_SOFT_TRIGGER_CMD];
	endsequence
	sequence restartedSeq;
		count_q == '0 && clkRun_q;
	endsequence

	count_read_a: assert property (regRd && regAddr == `TWC_COUNT_OFS |=>
		regRdata == 32'($past(count_q))) else $error("count read mismatch");
	cmpa_read_a: assert property (regRd && regAddr == `TWC_CMPA_OFS |=>
		regRdata == 32'($past(cmpA_q))) else $error("compare_a read mismatch");
	cmpb_read_a: assert property (regRd && regAddr == `TWC_CMPB_OFS |=>
		regRdata == 32'($past(cmpB_q))) else $error("compare_b read mismatch");
	cmpc_read_a: assert property (regRd && regAddr == `TWC_CMPC_OFS |=>
		regRdata == 32'($past(cmpC_q))) else $error("compare_c read mismatch");
	cmpa_lock_a: assert property (!mode_q.waveMode |=> $stable(cmpA_q))
		else $error("compare_a changed in capture operation");
	sw_restart_a: assert property (swWriteSeq ##0 !(matchC && mode_q.stopOnTopMatch)
		##0 !(matchC && mode_q.disableOnTopMatch) |=> restartedSeq)
		else $error("software trigger did not restart");
	top_stop_a: assert property (matchC && mode_q.stopOnTopMatch |=> !clkRun_q ##1
		(!clkRun_q || $past(trig))) else $error("clock not stopped on compare_c");
	top_disable_a: assert property (matchC && mode_q.disableOnTopMatch |=>
		!clkEn_q) else $error("clock not disabled on compare_c");
	flag_sticky_a: assert property (matchC |=> flag_q[2] [*1] ##0
		(flag_q[2] throughout (!statusRd [*1]))) else $error("compare_c flag lost");
	event_quiet_a: assert property (evtQual && !mode_q.eventRestartEnable && !swTrig &&
		!autoTrig && !tick |=> count_q == $past(count_q)) else $error("event moved counter");
	event_restart_a: assert property (evtQual && mode_q.eventRestartEnable |=>
		count_q == '0) else $error("event did not zero counter");
	up_wrap_a: assert property (tick && !trig && count_q == {CNT_W{1'b1}} &&
		mode_q.waveformShapeSelect == `TWC_SHAPE_UP |=> count_q == '0)
		else $error("up counter did not wrap");
	iob_input_a: assert property (bIsInput |-> !chanIoBOe)
		else $error("input line driven");
	edge_none_a: assert property (mode_q.eventEdgeSelect == 2'h0 |-> !evtQual)
		else $error("event with no edge selected");
	capture_idle_a: assert property (!mode_q.waveMode |-> !chanIoAOe &&
		!chanIoBOe) else $error("lines driven in capture operation");
	outa_set_a: assert property (swWriteSeq ##0 mode_q.waveMode &&
		mode_q.outaOnSoftTrigger == `TWC_ACT_SET |=> chanIoAOut)
		else $error("chan_io_a not set by software trigger");
	outb_clear_a: assert property (swWriteSeq ##0 mode_q.waveMode && !bIsInput &&
		mode_q.outbOnSoftTrigger == `TWC_ACT_CLEAR |=> !chanIoBOut)
		else $error("chan_io_b not cleared by software trigger");

endmodule

`default_nettype wire

/* timer_channel_far_side.sv */
// Far-side model of the waveform channel: prescaled clock sources and the chan_io_b pin.
// Assumes the bench asks for the level it wants on the pin while the channel leaves it.
`timescale 1ns/1ps
`default_nettype none

module timer_channel_far_side (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Pin request and channel side of chan_io_b
	input wire logic pinLevel,
	input wire logic chanIoBOut,
	input wire logic chanIoBOe,
	output logic chanIoBIn,
	// Clock sources
	output logic [4:0] prescaledClk
);
	logic [5:0] divCnt_q;

	// ==========================================
	// Prescaled clocks
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			divCnt_q <= 6'h00;
		end else begin
			divCnt_q <= divCnt_q + 6'h01;
		end
	end
	// Skip bit 0 so that every level holds at least two core cycles, as the channel needs
	assign prescaledClk = divCnt_q[5:1];

	// ==========================================
	// Pin level
	// Channel wins while it drives, otherwise the far side owns the line
	assign chanIoBIn = chanIoBOe ? chanIoBOut : pinLevel;
endmodule

`default_nettype wire

/* test_timer_waveform_channel.sv */
// Self-checking bench of the waveform channel: registers, clock sources, compares,
// shapes, triggers and events. Assumes the far-side model and the constants header.
`timescale 1ns/1ps
`include "timer_waveform_channel_consts.svh"
`default_nettype none

module test_timer_waveform_channel
	import timer_waveform_channel_pkg::*;
;
	logic core_clk, rst_b, regWr, regRd, pinLevel, chanIoBIn;
	logic chanIoAOut, chanIoAOe, chanIoBOut, chanIoBOe, expA, expB, down1;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata, c0, c1, maxv;
	logic [4:0] prescaledClk;
	logic [2:0] extClk;
	logic [1:0] ca;
	int failures, n_tests, seed;
	mode_t m;

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	timer_waveform_channel timer_waveform_channel_i (.core_clk(core_clk), .rst_b(rst_b),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .prescaledClk(prescaledClk), .extClk(extClk),
		.chanIoBIn(chanIoBIn), .chanIoAOut(chanIoAOut), .chanIoAOe(chanIoAOe),
		.chanIoBOut(chanIoBOut), .chanIoBOe(chanIoBOe));
	timer_channel_far_side timer_channel_far_side_i (.core_clk(core_clk), .rst_b(rst_b),
		.pinLevel(pinLevel), .chanIoBOut(chanIoBOut), .chanIoBOe(chanIoBOe),
		.chanIoBIn(chanIoBIn), .prescaledClk(prescaledClk));

	// ==========================================
	// Bus, stimulus and compare helpers
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1;
		d = regRdata;
	endtask
	task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkPin(input logic got, input logic exp);
		chkVal({31'h0, got}, {31'h0, exp});
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		rd(a, c1);
		chkVal(c1, exp);
	endtask
	// Registered outputs are looked at just past the edge, never on it
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic pulse(input int i);
		extClk[i] <= 1'b1;
		settle(3);
		extClk[i] <= 1'b0;
		settle(3);
	endtask
	task automatic trig(input logic [31:0] cmd);
		wr(`TWC_CTRL_OFS, cmd);
		settle(3);
	endtask
	task automatic note(input string s);
		$display("test %s done", s);
	endtask
	function automatic mode_t baseMode();
		mode_t v;
		v = '0;
		v.waveMode = 1'b1;
		v.eventSourceSelect = 2'h3;
		v.clockSourceSelect = 3'h5;
		return v;
	endfunction
	function automatic logic nextOut(input logic [1:0] act, input logic old);
		case (act)
			`TWC_ACT_SET: return 1'b1;
			`TWC_ACT_CLEAR: return 1'b0;
			`TWC_ACT_TOGGLE: return ~old;
			default: return old;
		endcase
	endfunction
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge core_clk);
		failures++;
		$display("ERROR t=%0t run limit got=%h exp=%h", $time, 1'b0, 1'b1);
		complete_run();
	end

	initial begin
		seed = 29;
		failures = 0;
		n_tests = 0;
		rst_b = 1'b0;
		regAddr = 8'h00;
		regWdata = 32'h0;
		regWr = 1'b0;
		regRd = 1'b0;
		extClk = 3'h0;
		pinLevel = 1'b0;
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		// ==========================================
		// Reset values, unmapped holes included
		for (int i = 1; i < 9; i++) begin
			rdChk(8'(4 * i), 32'h0);
		end
		note("reset");
		// ==========================================
		// Compare access in both operating modes
		wr(`TWC_CMPA_OFS, 32'h1234);
		wr(`TWC_CMPB_OFS, 32'h5678);
		rdChk(`TWC_CMPA_OFS, 32'h0);
		rdChk(`TWC_CMPB_OFS, 32'h0);
		chkPin(chanIoAOe, 1'b0);
		m = baseMode();
		wr(`TWC_MODE_OFS, m);
		rdChk(`TWC_MODE_OFS, m);
		chkPin(chanIoAOe, 1'b1);
		chkPin(chanIoBOe, 1'b1);
		for (int i = 0; i < 3; i++) begin
			c0 = $random(seed);
			wr(8'(`TWC_CMPA_OFS + 4 * i), c0);
			rdChk(8'(`TWC_CMPA_OFS + 4 * i), {16'h0, c0[15:0]});
		end
		wr(`TWC_COUNT_OFS, 32'hbeef);
		rdChk(`TWC_COUNT_OFS, 32'h0);
		note("registers");
		// ==========================================
		// Clock sources: two counter edges per window
		for (int k = 0; k < 8; k++) begin
			m.clockSourceSelect = 3'(k);
			wr(`TWC_MODE_OFS, m);
			trig(32'h5);
			rd(`TWC_COUNT_OFS, c0);
			if (k < 5) begin
				repeat ((8 << k) - 2) @(posedge core_clk);
			end else begin
				pulse(k - 5);
				pulse(k - 5);
			end
			rd(`TWC_COUNT_OFS, c1);
			chkVal(c1 - c0, 32'h2);
		end
		m.clockSourceSelect = 3'h5;
		m.countEdgeInvert = 1'b1;
		wr(`TWC_MODE_OFS, m);
		trig(32'h5);
		rd(`TWC_COUNT_OFS, c0);
		extClk[0] <= 1'b1;
		settle(3);
		rdChk(`TWC_COUNT_OFS, c0);
		extClk[0] <= 1'b0;
		settle(3);
		rdChk(`TWC_COUNT_OFS, c0 + 32'h1);
		m.countEdgeInvert = 1'b0;
		m.clockSourceSelect = 3'h0;
		m.gateSelect = 2'h2;
		wr(`TWC_MODE_OFS, m);
		trig(32'h5);
		rd(`TWC_COUNT_OFS, c0);
		repeat (14) @(posedge core_clk);
		rdChk(`TWC_COUNT_OFS, c0);
		// Opening the gate mid-level could add an edge, so let it settle first
		extClk[1] <= 1'b1;
		settle(4);
		rd(`TWC_COUNT_OFS, c0);
		repeat (6) @(posedge core_clk);
		rdChk(`TWC_COUNT_OFS, c0 + 32'h2);
		extClk[1] <= 1'b0;
		note("clock sources");
		// ==========================================
		// Compares, stop, disable and sticky flag
		m = baseMode();
		m.stopOnTopMatch = 1'b1;
		m.outaOnMatchA = `TWC_ACT_SET;
		m.outaOnMatchC = `TWC_ACT_CLEAR;
		m.outbOnMatchB = `TWC_ACT_SET;
		m.outbOnMatchC = `TWC_ACT_CLEAR;
		m.outaOnSoftTrigger = `TWC_ACT_CLEAR;
		m.outbOnSoftTrigger = `TWC_ACT_CLEAR;
		wr(`TWC_MODE_OFS, m);
		for (int i = 0; i < 3; i++) begin
			wr(8'(`TWC_CMPA_OFS + 4 * i), 32'(i + 2));
		end
		trig(32'h5);
		rd(`TWC_STATUS_OFS, c0);
		chkPin(chanIoAOut, 1'b0);
		chkPin(chanIoBOut, 1'b0);
		pulse(0);
		pulse(0);
		chkPin(chanIoAOut, 1'b1);
		chkPin(chanIoBOut, 1'b0);
		pulse(0);
		chkPin(chanIoBOut, 1'b1);
		pulse(0);
		chkPin(chanIoAOut, 1'b0);
		chkPin(chanIoBOut, 1'b0);
		pulse(0);
		rdChk(`TWC_COUNT_OFS, 32'h4);
		rd(`TWC_STATUS_OFS, c0);
		chkVal(c0 & 32'h7_009c, 32'h1_001c);
		rd(`TWC_STATUS_OFS, c0);
		chkVal(c0 & 32'h10, 32'h0);
		trig(32'h4);
		rdChk(`TWC_COUNT_OFS, 32'h0);
		pulse(0);
		rdChk(`TWC_COUNT_OFS, 32'h1);
		for (int d = 0; d < 2; d++) begin
			m.stopOnTopMatch = 1'b0;
			m.disableOnTopMatch = (d == 0);
			wr(`TWC_MODE_OFS, m);
			trig(32'h5);
			repeat (5) pulse(0);
			rdChk(`TWC_COUNT_OFS, 32'(5 - (d == 0)));
			rd(`TWC_STATUS_OFS, c0);
			chkVal(c0 & 32'h1_0000, 32'(d) << 16);
		end
		note("compares");
		// ==========================================
		// Waveform shapes against a top of 3
		wr(`TWC_CMPC_OFS, 32'h3);
		for (int s = 0; s < 4; s++) begin
			m = baseMode();
			m.clockSourceSelect = 3'h0;
			m.waveformShapeSelect = 2'(s);
			wr(`TWC_MODE_OFS, m);
			trig(32'h5);
			maxv = 32'h0;
			down1 = 1'b0;
			rd(`TWC_COUNT_OFS, c0);
			repeat (30) begin
				rd(`TWC_COUNT_OFS, c1);
				if (c1 > maxv) maxv = c1;
				if (c0 - c1 == 32'h1) down1 = 1'b1;
				c0 = c1;
			end
			chkPin(maxv == 32'h3, s[1]);
			chkPin(down1, s == 3);
		end
		note("shapes");
		// ==========================================
		// Software trigger actions, every code and random ones
		m = baseMode();
		for (int i = 0; i < 12; i++) begin
			ca = 2'(i) ^ 2'h2;
			m.outaOnSoftTrigger = ca;
			m.outbOnSoftTrigger = (i == 0) ? 2'h2 : 2'($random(seed));
			wr(`TWC_MODE_OFS, m);
			trig(32'h4);
			expA = nextOut(ca, expA);
			expB = nextOut(m.outbOnSoftTrigger, expB);
			chkPin(chanIoAOut, expA);
			chkPin(chanIoBOut, expB);
		end
		note("soft trigger");
		// ==========================================
		// External events on clock 1, each edge code, restart off and on
		for (int e = 0; e < 8; e++) begin
			m = baseMode();
			m.eventSourceSelect = 2'h2;
			m.eventEdgeSelect = 2'(e);
			m.eventRestartEnable = e[2];
			m.outaOnEvent = `TWC_ACT_TOGGLE;
			m.outaOnSoftTrigger = `TWC_ACT_CLEAR;
			wr(`TWC_MODE_OFS, m);
			trig(32'h5);
			pulse(0);
			pulse(0);
			extClk[1] <= 1'b1;
			settle(4);
			chkPin(chanIoAOut, e[0]);
			rdChk(`TWC_COUNT_OFS, (e[2] && e[0]) ? 32'h0 : 32'h2);
			extClk[1] <= 1'b0;
			settle(4);
			chkPin(chanIoAOut, e[0] ^ e[1]);
			rdChk(`TWC_COUNT_OFS, (e[2] && e[1:0] != 0) ? 32'h0 : 32'h2);
		end
		note("events");
		// ==========================================
		// chan_io_b as event input
		m = baseMode();
		m.eventSourceSelect = `TWC_EVT_FROM_IOB;
		m.eventEdgeSelect = 2'h1;
		m.outaOnEvent = `TWC_ACT_TOGGLE;
		m.outaOnSoftTrigger = `TWC_ACT_CLEAR;
		m.outbOnSoftTrigger = `TWC_ACT_SET;
		wr(`TWC_MODE_OFS, m);
		trig(32'h4);
		chkPin(chanIoBOe, 1'b0);
		pinLevel <= 1'b1;
		settle(4);
		chkPin(chanIoAOut, 1'b1);
		chkPin(chanIoBOe, 1'b0);
		note("pin event");
		complete_run();
	end
endmodule

`default_nettype wire
